// ==== pri_pkg.sv ====
// Constants shared by the priority interrupt controller
package pri_pkg;
    localparam int NUM_SRC   = 8;
    localparam int NUM_TRAP  = 4;
    localparam int NUM_EVT   = 4;
    localparam int STK_DEPTH = 8;
    localparam logic [3:0] STK_FULL = 4'h8;

    // Register byte offsets
    localparam logic [7:0] ADR_CTRL1 = 8'h00;
    localparam logic [7:0] ADR_PEND  = 8'h04;
    localparam logic [7:0] ADR_ENAB  = 8'h08;
    localparam logic [7:0] ADR_PRIO0 = 8'h0C;
    localparam logic [7:0] ADR_PRIO3 = 8'h10;
    localparam logic [7:0] ADR_SRL   = 8'h14;
    localparam logic [7:0] ADR_TIMED_DISABLE_INSTR  = 8'h18;
    localparam logic [7:0] ADR_ISTAT = 8'h1C;
    localparam logic [7:0] ADR_IMASK = 8'h20;
    localparam logic [7:0] ADR_STATE = 8'h24;

    // Field positions
    localparam int NEST_DIS_BIT = 15;
    localparam int SRL_PRIO_LSB = 5;
    localparam int PRIO_FIELD_W = 4;

    // Levels and reset values
    localparam logic [2:0]  PRIO_RESET  = 3'h4;
    localparam logic [2:0]  PRIO_OFF    = 3'h0;
    localparam logic [2:0]  PRIO_TOP    = 3'h7;
    localparam logic [3:0]  TRAP_BASE   = 4'h8;
    localparam logic [3:0]  TIMED_DISABLE_INSTR_TOP    = 4'h6;
    localparam logic [3:0]  LVL_RESET   = 4'h0;
    localparam logic [15:0] TIMED_DISABLE_INSTR_RESET  = 16'h0000;

    // Sticky event bit positions
    localparam int EVT_IRQ      = 0;
    localparam int EVT_TRAP     = 1;
    localparam int EVT_RET      = 2;
    localparam int EVT_TIMED_DISABLE_INSTR_END = 3;
endpackage : pri_pkg

// ==== pri_controller.sv ====
// Priority interrupt controller with Wishbone register slave
//
// Overview of operation
// - Three-bit priority; 111 top, 000 disables
// - Reset sets every user priority to 4
// - Nesting disable blocks user sources preempting a running handler
// - Only enabled sources may request service
// - Pending stays until cleared; retaken after return
// - Return restores saved PC, status byte, level
// - Trap flag stays set; trap re-entered otherwise
// - Status priority bits all ones mask levels 1-7
// - Traps at levels 8-11 never masked
// - Timed disable holds levels 1-6, not 7
`timescale 1ns/1ps
module pri_controller
    import pri_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     irq_out,
    input  wire logic [NUM_SRC-1:0]  srcEvent,
    input  wire logic [NUM_TRAP-1:0] trapEvent,
    input  wire logic                coreAck,
    input  wire logic                coreReturn,
    input  wire logic [15:0]         corePc,
    output logic                     coreReq,
    output logic      [3:0]          coreVector,
    output logic      [3:0]          coreLevel,
    output logic                     retValid,
    output logic      [15:0]         retPc,
    output logic      [7:0]          retSrl,
    output logic      [3:0]          retLevel
);

    // Byte-lane merge of a 16-bit register write
    function automatic logic [15:0] mergeWr(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        mergeWr = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : mergeWr

    // Pack four priority fields into a 16-bit register image
    function automatic logic [15:0] packPrio(input logic [3:0][2:0] p);
        packPrio = {1'b0, p[3], 1'b0, p[2], 1'b0, p[1], 1'b0, p[0]};
    endfunction : packPrio

    ////////////////////////////////////////////////////////////////////////
    // State
    logic                    ack_r,      ack_nxt;
    logic [31:0]             rdata_r,    rdata_nxt;
    logic [NUM_SRC-1:0]      pend_r,     pend_nxt;
    logic [NUM_SRC-1:0]      enab_r,     enab_nxt;
    logic [NUM_SRC-1:0][2:0] prio_r,     prio_nxt;
    logic                    nestDis_r,  nestDis_nxt;
    logic [NUM_TRAP-1:0]     trapFlag_r, trapFlag_nxt;
    logic [3:0]              cpuLevel_r, cpuLevel_nxt;
    logic [4:0]              srlLow_r,   srlLow_nxt;
    logic [15:0]             disiCnt_r,  disiCnt_nxt;
    logic [NUM_EVT-1:0]      istat_r,    istat_nxt;
    logic [NUM_EVT-1:0]      imask_r,    imask_nxt;
    logic [3:0]              sp_r,       sp_nxt;
    logic                    irq_r,      irq_nxt;
    logic                    req_r,      req_nxt;
    logic [3:0]              vec_r,      vec_nxt;
    logic [3:0]              lvl_r,      lvl_nxt;
    logic                    retV_r,     retV_nxt;
    logic [15:0]             retPc_r,    retPc_nxt;
    logic [7:0]              retSrl_r,   retSrl_nxt;
    logic [3:0]              retLvl_r,   retLvl_nxt;

    // Save stack; one entry per nested handler
    logic [15:0] stkPc  [STK_DEPTH];
    logic [4:0]  stkSrl [STK_DEPTH];
    logic [3:0]  stkLvl [STK_DEPTH];

    logic        busAcc;
    logic        busWr;
    logic [3:0]  bestLvl;
    logic [3:0]  bestIdx;
    logic        take;
    logic        accept;
    logic        popOk;
    logic [2:0]  popIdx;
    logic [2:0]  srlPrio;
    logic [15:0] wrd;
    logic [15:0] ctrlWr;

    assign busAcc  = wb_cyc_i & wb_stb_i & ~ack_r;
    assign busWr   = busAcc & wb_we_i;
    assign accept  = coreAck & req_r;
    assign popOk   = coreReturn & ~accept & (sp_r != 4'h0);
    assign popIdx  = 3'(sp_r - 4'h1);
    assign srlPrio = cpuLevel_r[3] ? PRIO_TOP : cpuLevel_r[2:0];
    assign wrd     = wb_dat_i[15:0];
    // Control register image after a byte-lane write; a call result cannot be bit-selected
    assign ctrlWr  = mergeWr({nestDis_r, 11'h000, trapFlag_r}, wb_dat_i, wb_sel_i);

    ////////////////////////////////////////////////////////////////////////
    // Arbitration: scan low to high with strict compare, so ties go to the lowest source
    always_comb begin
        bestLvl = LVL_RESET;
        bestIdx = 4'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend_r[i] && enab_r[i] && (prio_r[i] != PRIO_OFF)
                && !((disiCnt_r != TIMED_DISABLE_INSTR_RESET) && ({1'b0, prio_r[i]} <= TIMED_DISABLE_INSTR_TOP))
                && !(nestDis_r && (sp_r != 4'h0))
                && ({1'b0, prio_r[i]} > bestLvl)) begin
                bestLvl = {1'b0, prio_r[i]};
                bestIdx = 4'(i);
            end
        end
        // Traps sit above every user level and ignore all masking
        for (int j = 0; j < NUM_TRAP; j++) begin
            if (trapFlag_r[j] && ((TRAP_BASE + 4'(j)) > bestLvl)) begin
                bestLvl = TRAP_BASE + 4'(j);
                bestIdx = TRAP_BASE + 4'(j);
            end
        end
        take = (bestLvl > cpuLevel_r) && (sp_r != STK_FULL);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for registers, core handshake and save stack
    always_comb begin
        ack_nxt      = busAcc;
        rdata_nxt    = rdata_r;
        pend_nxt     = pend_r;
        enab_nxt     = enab_r;
        prio_nxt     = prio_r;
        nestDis_nxt  = nestDis_r;
        trapFlag_nxt = trapFlag_r;
        cpuLevel_nxt = cpuLevel_r;
        srlLow_nxt   = srlLow_r;
        disiCnt_nxt  = (disiCnt_r != TIMED_DISABLE_INSTR_RESET) ? disiCnt_r - 16'h0001 : disiCnt_r;
        istat_nxt    = istat_r;
        imask_nxt    = imask_r;
        sp_nxt       = sp_r;
        retV_nxt     = 1'b0;
        retPc_nxt    = retPc_r;
        retSrl_nxt   = retSrl_r;
        retLvl_nxt   = retLvl_r;

        // Software writes; hardware sets below win over any clear
        if (busWr) begin
            unique case (wb_adr_i)
                ADR_CTRL1: begin
                    nestDis_nxt  = ctrlWr[NEST_DIS_BIT];
                    trapFlag_nxt = ctrlWr[NUM_TRAP-1:0];
                end
                ADR_PEND:  pend_nxt = wb_sel_i[0] ? wrd[7:0] : pend_r;
                ADR_ENAB:  enab_nxt = wb_sel_i[0] ? wrd[7:0] : enab_r;
                ADR_PRIO0, ADR_PRIO3: begin
                    for (int k = 0; k < 4; k++) begin
                        if (wb_sel_i[k / 2])
                            prio_nxt[k + ((wb_adr_i == ADR_PRIO3) ? 4 : 0)] = wrd[k*PRIO_FIELD_W +: 3];
                    end
                end
                ADR_SRL: begin
                    if (wb_sel_i[0]) begin
                        srlLow_nxt = wrd[4:0];
                        if (!cpuLevel_r[3])
                            cpuLevel_nxt = {1'b0, wrd[7:SRL_PRIO_LSB]};
                    end
                end
                ADR_TIMED_DISABLE_INSTR:  disiCnt_nxt = mergeWr(disiCnt_r, wb_dat_i, wb_sel_i);
                ADR_ISTAT: istat_nxt = wb_sel_i[0] ? istat_r & ~wrd[NUM_EVT-1:0] : istat_r;
                ADR_IMASK: imask_nxt = wb_sel_i[0] ? wrd[NUM_EVT-1:0] : imask_r;
                default: ;
            endcase
        end

        // Register reads; unmapped offsets read as zero
        if (busAcc && !wb_we_i) begin
            unique case (wb_adr_i)
                ADR_CTRL1: rdata_nxt = {16'h0000, nestDis_r, 11'h000, trapFlag_r};
                ADR_PEND:  rdata_nxt = {24'h000000, pend_r};
                ADR_ENAB:  rdata_nxt = {24'h000000, enab_r};
                ADR_PRIO0: rdata_nxt = {16'h0000, packPrio(prio_r[3:0])};
                ADR_PRIO3: rdata_nxt = {16'h0000, packPrio(prio_r[7:4])};
                ADR_SRL:   rdata_nxt = {24'h000000, srlPrio, srlLow_r};
                ADR_TIMED_DISABLE_INSTR:  rdata_nxt = {16'h0000, disiCnt_r};
                ADR_ISTAT: rdata_nxt = {28'h0000000, istat_r};
                ADR_IMASK: rdata_nxt = {28'h0000000, imask_r};
                ADR_STATE: rdata_nxt = {16'h0000, sp_r, cpuLevel_r, vec_r, lvl_r};
                default:   rdata_nxt = 32'h00000000;
            endcase
        end

        // Hardware sets: flags stay until software clears them
        pend_nxt     = pend_nxt | srcEvent;
        trapFlag_nxt = trapFlag_nxt | trapEvent;

        // Core takes the presented request: save context, raise level
        if (accept) begin
            sp_nxt       = sp_r + 4'h1;
            cpuLevel_nxt = lvl_r;
            istat_nxt[lvl_r[3] ? EVT_TRAP : EVT_IRQ] = 1'b1;
        end else if (popOk) begin
            sp_nxt       = sp_r - 4'h1;
            cpuLevel_nxt = stkLvl[popIdx];
            srlLow_nxt   = stkSrl[popIdx];
            retV_nxt     = 1'b1;
            retPc_nxt    = stkPc[popIdx];
            retSrl_nxt   = {stkLvl[popIdx][3] ? PRIO_TOP : stkLvl[popIdx][2:0], stkSrl[popIdx]};
            retLvl_nxt   = stkLvl[popIdx];
            istat_nxt[EVT_RET] = 1'b1;
        end
        if (disiCnt_r == 16'h0001 && !(busWr && wb_adr_i == ADR_TIMED_DISABLE_INSTR))
            istat_nxt[EVT_TIMED_DISABLE_INSTR_END] = 1'b1;

        // Drop the request for the cycle after acceptance, until the new level settles
        req_nxt = take && !accept;
        vec_nxt = bestIdx;
        lvl_nxt = bestLvl;
        irq_nxt = |(istat_r & imask_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ack_r      <= 1'b0;
            rdata_r    <= 32'h00000000;
            pend_r     <= '0;
            enab_r     <= '0;
            prio_r     <= {NUM_SRC{PRIO_RESET}};
            nestDis_r  <= 1'b0;
            trapFlag_r <= '0;
            cpuLevel_r <= LVL_RESET;
            srlLow_r   <= 5'h00;
            disiCnt_r  <= TIMED_DISABLE_INSTR_RESET;
            istat_r    <= '0;
            imask_r    <= '0;
            sp_r       <= 4'h0;
            irq_r      <= 1'b0;
            req_r      <= 1'b0;
            vec_r      <= 4'h0;
            lvl_r      <= LVL_RESET;
            retV_r     <= 1'b0;
            retPc_r    <= 16'h0000;
            retSrl_r   <= 8'h00;
            retLvl_r   <= LVL_RESET;
        end else begin
            ack_r      <= ack_nxt;
            rdata_r    <= rdata_nxt;
            pend_r     <= pend_nxt;
            enab_r     <= enab_nxt;
            prio_r     <= prio_nxt;
            nestDis_r  <= nestDis_nxt;
            trapFlag_r <= trapFlag_nxt;
            cpuLevel_r <= cpuLevel_nxt;
            srlLow_r   <= srlLow_nxt;
            disiCnt_r  <= disiCnt_nxt;
            istat_r    <= istat_nxt;
            imask_r    <= imask_nxt;
            sp_r       <= sp_nxt;
            irq_r      <= irq_nxt;
            req_r      <= req_nxt;
            vec_r      <= vec_nxt;
            lvl_r      <= lvl_nxt;
            retV_r     <= retV_nxt;
            retPc_r    <= retPc_nxt;
            retSrl_r   <= retSrl_nxt;
            retLvl_r   <= retLvl_nxt;
        end
    end

    // Stack push; contents need no reset since the pointer guards them
    always_ff @(posedge sys_clk) begin
        if (accept) begin
            stkPc[sp_r[2:0]]  <= corePc;
            stkSrl[sp_r[2:0]] <= srlLow_r;
            stkLvl[sp_r[2:0]] <= cpuLevel_r;
        end
    end

    assign wb_dat_o   = rdata_r;
    assign wb_ack_o   = ack_r;
    assign irq_out    = irq_r;
    assign coreReq    = req_r;
    assign coreVector = vec_r;
    assign coreLevel  = lvl_r;
    assign retValid   = retV_r;
    assign retPc      = retPc_r;
    assign retSrl     = retSrl_r;
    assign retLevel   = retLvl_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_prio_reset;
        $past(!nrst) |-> (prio_r == {NUM_SRC{PRIO_RESET}});
    endproperty
    a_prio_reset: assert property (p_prio_reset) else $error("priorities not 4 after reset");

    property p_zero_off;
        req_nxt && !bestLvl[3] |-> (bestLvl != LVL_RESET) && (prio_r[bestIdx[2:0]] != PRIO_OFF);
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("disabled source presented");

    property p_enabled;
        req_nxt && !bestLvl[3] |-> enab_r[bestIdx[2:0]] && pend_r[bestIdx[2:0]];
    endproperty
    a_enabled: assert property (p_enabled) else $error("unenabled source presented");

    property p_above_cpu;
        req_r |-> lvl_r > $past(cpuLevel_r);
    endproperty
    a_above_cpu: assert property (p_above_cpu) else $error("request not above CPU level");

    property p_nest;
        $past(nestDis_r && sp_r != 4'h0) && req_r |-> lvl_r >= TRAP_BASE;
    endproperty
    a_nest: assert property (p_nest) else $error("user preemption while nesting disabled");

    property p_timed_disable_instr;
        $past(disiCnt_r != TIMED_DISABLE_INSTR_RESET) && req_r && !lvl_r[3] |-> lvl_r == {1'b0, PRIO_TOP};
    endproperty
    a_timed_disable_instr: assert property (p_timed_disable_instr) else $error("level 1-6 served during timed disable");

    property p_trap;
        trapFlag_r[0] && cpuLevel_r < TRAP_BASE && sp_r != STK_FULL && !accept |=> req_r && lvl_r >= TRAP_BASE;
    endproperty
    a_trap: assert property (p_trap) else $error("trap masked");

    property p_srl;
        busWr && wb_adr_i == ADR_SRL && wb_sel_i[0] && wrd[7:5] == PRIO_TOP && !cpuLevel_r[3] && !accept && !popOk
            |=> cpuLevel_r == {1'b0, PRIO_TOP} ##1 !req_r || lvl_r[3];
    endproperty
    a_srl: assert property (p_srl) else $error("status write did not raise level");

    property p_ret;
        popOk |=> retValid && cpuLevel_r == retLevel && retSrl[4:0] == srlLow_r;
    endproperty
    a_ret: assert property (p_ret) else $error("return did not restore context");

    property p_pend_hold;
        pend_r[0] && !(busWr && wb_adr_i == ADR_PEND && wb_sel_i[0]) |=> pend_r[0];
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending flag lost");

    property p_trap_hold;
        trapFlag_r[0] && !(busWr && wb_adr_i == ADR_CTRL1 && wb_sel_i[0]) |=> trapFlag_r[0];
    endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("trap flag lost");

    c_user: cover property (accept && !lvl_r[3]);
    c_trap: cover property (accept && lvl_r[3]);
    c_nested: cover property (accept && sp_r != 4'h0);
    c_retake: cover property (popOk ##[1:4] accept);
endmodule : pri_controller

// ==== pri_core_model.sv ====
// Processor core model: accepts presented requests and issues returns
`timescale 1ns/1ps
module pri_core_model (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        coreReq,
    input  wire logic        ackEn,
    input  wire logic [3:0]  ackDelay,
    input  wire logic        retCmd,
    output logic             coreAck,
    output logic             coreReturn,
    output logic      [15:0] corePc
);
    logic [3:0]  waitCnt_r;
    logic [3:0]  waitCnt_nxt;
    logic        ack_nxt;
    logic        ret_nxt;
    logic [15:0] pc_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Accept after ackDelay cycles; PC advances only on a real accept
    always_comb begin
        ack_nxt     = 1'b0;
        waitCnt_nxt = 4'h0;
        pc_nxt      = corePc;
        if (coreAck && coreReq) begin
            pc_nxt = corePc + 16'h0010;
        end else if (ackEn && coreReq && !coreAck) begin
            if (waitCnt_r == ackDelay) begin
                ack_nxt = 1'b1;
            end else begin
                waitCnt_nxt = waitCnt_r + 4'h1;
            end
        end
        // A real core never returns in the cycle it accepts
        ret_nxt = retCmd && !ack_nxt;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            waitCnt_r  <= 4'h0;
            coreAck    <= 1'b0;
            coreReturn <= 1'b0;
            corePc     <= 16'h1000;
        end else begin
            waitCnt_r  <= waitCnt_nxt;
            coreAck    <= ack_nxt;
            coreReturn <= ret_nxt;
            corePc     <= pc_nxt;
        end
    end
endmodule : pri_core_model

// ==== tb_top.sv ====
// Self-checking testbench for the priority interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top
    import pri_pkg::*;
;
    logic                sys_clk;
    logic                nrst;
    logic [7:0]          wbAdr;
    logic [31:0]         wbDatI;
    logic [31:0]         wbDatO;
    logic [3:0]          wbSel;
    logic                wbWe;
    logic                wbCyc;
    logic                wbStb;
    logic                wbAck;
    logic                irqOut;
    logic [NUM_SRC-1:0]  srcEvent;
    logic [NUM_TRAP-1:0] trapEvent;
    logic                coreAck;
    logic                coreReturn;
    logic [15:0]         corePc;
    logic                coreReq;
    logic [3:0]          coreVector;
    logic [3:0]          coreLevel;
    logic                retValid;
    logic [15:0]         retPc;
    logic [7:0]          retSrl;
    logic [3:0]          retLevel;
    logic                ackEn;
    logic [3:0]          ackDelay;
    logic                retCmd;
    int                  n_fail;
    int                  compares;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and core model
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    pri_controller dut (.sys_clk(sys_clk), .nrst(nrst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel),
        .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq_out(irqOut),
        .srcEvent(srcEvent), .trapEvent(trapEvent), .coreAck(coreAck), .coreReturn(coreReturn), .corePc(corePc),
        .coreReq(coreReq), .coreVector(coreVector), .coreLevel(coreLevel), .retValid(retValid), .retPc(retPc),
        .retSrl(retSrl), .retLevel(retLevel));

    pri_core_model core (.sys_clk(sys_clk), .nrst(nrst), .coreReq(coreReq), .ackEn(ackEn), .ackDelay(ackDelay),
        .retCmd(retCmd), .coreAck(coreAck), .coreReturn(coreReturn), .corePc(corePc));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // One classic cycle; idle cycle before raising keeps stb low between requests
    task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [15:0] d, output logic [15:0] q);
        int k;
        @(posedge sys_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbAdr  <= a;
        wbWe   <= we;
        wbDatI <= {16'h0000, d};
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (wbAck === 1'b1) break;
        end
        q = wbDatO[15:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (k == 20) begin n_fail++; final_report(); end
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb_xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input string nm);
        logic [15:0] q;
        wb_xfer(a, 1'b0, 16'h0000, q);
        `CHK(nm, e, q & m)
    endtask : chk_rd

    task automatic pulse(input logic [7:0] s, input logic [3:0] t);
        @(posedge sys_clk);
        srcEvent  <= s;
        trapEvent <= t;
        @(posedge sys_clk);
        srcEvent  <= 8'h00;
        trapEvent <= 4'h0;
    endtask : pulse

    // Watch n cycles for a presented request and check what it carries
    task automatic chk_req(input int n, input logic expReq, input logic [3:0] v, input logic [3:0] l);
        logic seen;
        int   k;
        seen = 1'b0;
        for (k = 0; k < n && !seen; k++) begin
            @(posedge sys_clk);
            seen = (coreReq === 1'b1);
        end
        `CHK("coreReq", expReq, seen)
        if (expReq && seen) begin
            `CHK("coreVector", v, coreVector)
            `CHK("coreLevel", l, coreLevel)
        end
        if (expReq && !seen) final_report();
    endtask : chk_req

    task automatic accept;
        int k;
        ackEn <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (coreAck === 1'b1 && coreReq === 1'b1) break;
        end
        ackEn <= 1'b0;
        if (k == 20) begin n_fail++; final_report(); end
    endtask : accept

    task automatic do_return(input logic [15:0] pc, input logic [3:0] lvl);
        int k;
        @(posedge sys_clk);
        retCmd <= 1'b1;
        @(posedge sys_clk);
        retCmd <= 1'b0;
        for (k = 0; k < 10; k++) begin
            @(posedge sys_clk);
            if (retValid === 1'b1) break;
        end
        `CHK("retValid", 1'b1, retValid)
        `CHK("retPc", pc, retPc)
        `CHK("retLevel", lvl, retLevel)
        `CHK("retSrl", {lvl[2:0], 5'h00}, retSrl)
        if (k == 10) final_report();
    endtask : do_return

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_fail = 0;
        compares = 0;
        nrst = 1'b0;
        {wbCyc, wbStb, wbWe, ackEn, retCmd} = 5'h00;
        wbAdr = 8'h00;
        wbDatI = 32'h00000000;
        wbSel = 4'h3;
        srcEvent = 8'h00;
        trapEvent = 4'h0;
        ackDelay = 4'h0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        chk_rd(ADR_PRIO0, 16'hFFFF, 16'h4444, "prio0");
        chk_rd(ADR_PRIO3, 16'hFFFF, 16'h4444, "prio3");
        chk_rd(8'h3C, 16'hFFFF, 16'h0000, "unmapped");
        // Disabled priority, unarmed source, then a valid one
        wr(ADR_PEND, 16'h0000);
        wr(ADR_PRIO0, 16'h4504);
        wr(ADR_ENAB, 16'h0006);
        pulse(8'h02, 4'h0);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        pulse(8'h08, 4'h0);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        pulse(8'h04, 4'h0);
        chk_req(6, 1'b1, 4'h2, 4'h5);
        accept();
        chk_rd(ADR_STATE, 16'hFF00, 16'h1500, "state");
        // Sticky status, mask and level output
        chk_rd(ADR_ISTAT, 16'h0001, 16'h0001, "istat");
        `CHK("irq masked", 1'b0, irqOut)
        wr(ADR_IMASK, 16'h0001);
        chk_rd(ADR_IMASK, 16'hFFFF, 16'h0001, "imask");
        `CHK("irq raised", 1'b1, irqOut)
        wr(ADR_ISTAT, 16'h000F);
        chk_rd(ADR_ISTAT, 16'h000F, 16'h0000, "istat cleared");
        `CHK("irq cleared", 1'b0, irqOut)
        // Nesting disabled, then pending survives the return
        wr(ADR_CTRL1, 16'h8000);
        wr(ADR_PRIO0, 16'h4507);
        wr(ADR_ENAB, 16'h0007);
        pulse(8'h01, 4'h0);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        wr(ADR_PEND, 16'h0004);
        do_return(16'h1000, 4'h0);
        chk_req(4, 1'b1, 4'h2, 4'h5);
        wr(ADR_CTRL1, 16'h0000);
        wr(ADR_PEND, 16'h0000);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        // CPU at level 7; a trap still gets through, slow core
        wr(ADR_SRL, 16'h00E0);
        chk_rd(ADR_SRL, 16'h00E0, 16'h00E0, "srl");
        pulse(8'h01, 4'h0);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        pulse(8'h00, 4'h1);
        chk_req(6, 1'b1, 4'h8, 4'h8);
        ackDelay <= 4'h3;
        accept();
        chk_rd(ADR_CTRL1, 16'h000F, 16'h0001, "trap flag");
        do_return(16'h1010, 4'h7);
        chk_req(4, 1'b1, 4'h8, 4'h8);
        wr(ADR_CTRL1, 16'h0000);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        wr(ADR_PEND, 16'h0000);
        wr(ADR_SRL, 16'h0000);
        // Timed disable holds level 6 but not level 7
        wr(ADR_PRIO0, 16'h4576);
        wr(ADR_ENAB, 16'h0003);
        wr(ADR_TIMED_DISABLE_INSTR, 16'h0028);
        pulse(8'h01, 4'h0);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        pulse(8'h02, 4'h0);
        chk_req(6, 1'b1, 4'h1, 4'h7);
        wr(ADR_PEND, 16'h0001);
        chk_req(6, 1'b0, 4'h0, 4'h0);
        chk_req(60, 1'b1, 4'h0, 4'h6);
        final_report();
    end
endmodule : tb_top
